// >>> design/qa_watchdog_answer_check.sv
// The Wishbone interface to the registers and the placing of the registers were left to the implementer.
`include "qa_wd_regs.svh"
`default_nettype none
// Functional notes
// - A fixed table gives four reference bytes per question; question 0 expects FF, 0F, F0, 00.
// - The reference byte is chosen by the answer counter: 11b, 10b, 01b, then 00b.
// - A good sequence decrements the 3-bit fail counter and clears sequence-error and early.
// - Only a good sequence advances the question counter; other endings keep the question.
// - Correct values with a mistimed last byte count a failure and set sequence-error and early.
// - A wrong value with good timing counts a failure, sets sequence-error and clears early.
// - A wrong value with bad timing counts a failure and sets sequence-error and early.
// - A time-out counts a failure, keeps the question and sets the time-out flag.
// - A window-duration write counts a failure, sets config-changed and clears the other flags.
// - On a time-out, sequence-error reflects whether any byte received so far was wrong.
// - The answer counter starts each sequence at 11b and steps down on every answer write.
// - A new question and sequence start follow a good last answer within one cycle.
// - The question comes from a 4-bit counter and a 4-bit feedback shift chain.

module qa_watchdog_answer_check
(
  // System clock and synchronous reset.
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // Classic Wishbone slave.
  input  wire logic [7:0]  adr_i,
  input  wire logic [31:0] dat_i,
  input  wire logic [3:0]  sel_i,
  input  wire logic        we_i,
  input  wire logic        cyc_i,
  input  wire logic        stb_i,
  output logic      [31:0] dat_o,
  output logic             ack_o,
  // Window timer, same clock domain.
  input  wire logic        win2_active_i,
  input  wire logic        time_out_i,
  output logic             seq_start_o,
  output logic      [7:0]  open_window_o,
  output logic      [7:0]  closed_window_o,
  // Watchdog state.
  output logic      [3:0]  question_o,
  output logic      [2:0]  fail_counter_o,
  output logic             irq_o
);

  logic                ack_ff;
  logic [31:0]         rdat_ff;
  logic [3:0]          tok_cnt_ff;
  logic [3:0]          chain_ff;
  logic [3:0]          question_ff;
  qa_wd_pkg::fdbk_t    fdbk_ff;
  logic [1:0]          ans_cnt_ff;
  logic                ans_err_ff;
  logic                seq_error_ff;
  logic                tout_ff;
  logic                early_ff;
  logic                cfg_chg_ff;
  logic [2:0]          fail_ff;
  logic [7:0]          win1_ff;
  logic [7:0]          win2_ff;
  logic [3:0]          irq_stat_ff;
  logic [3:0]          irq_mask_ff;
  logic                seq_start_ff;
  logic [7:0]          ref_byte;
  logic [3:0]          nxt_tok_cnt;
  logic [3:0]          nxt_chain;
  logic [3:0]          chain_src;
  logic                chain_fb;
  logic [2:0]          nxt_fail;
  qa_wd_pkg::event_t   evt;

  // Bus decode; a write acts on the edge at which ack is high.
  wire        req      = cyc_i & stb_i;
  wire        wr_en    = req & we_i & ack_ff & sel_i[0];
  wire        hit_q    = (adr_i == `QA_ADR_QUESTION);
  wire        hit_fdbk = (adr_i == `QA_ADR_FDBK);
  wire        hit_ans  = (adr_i == `QA_ADR_ANSWER);
  wire        hit_win1 = (adr_i == `QA_ADR_WIN1);
  wire        hit_win2 = (adr_i == `QA_ADR_WIN2);
  wire        hit_st   = (adr_i == `QA_ADR_STATE);
  wire        hit_ist  = (adr_i == `QA_ADR_IRQ_STAT);
  wire        hit_imsk = (adr_i == `QA_ADR_IRQ_MASK);

  // Reference byte for the current question and answer position.
  qa_answer_ref u_ref
  (
    .question_i (question_ff),
    .position_i (ans_cnt_ff),
    .ref_byte_o (ref_byte)
  );

  // Event classification; a window write beats a time-out, which beats an answer.
  wire        ans_wr   = wr_en & hit_ans;
  wire        cfg_wr   = wr_en & (hit_win1 | hit_win2);
  wire        byte_ok  = (dat_i[7:0] == ref_byte);
  wire        last_ans = ans_wr & (ans_cnt_ff == 2'h0);
  wire        ev_cfg   = cfg_wr;
  wire        ev_tout  = time_out_i & ~cfg_wr;
  wire        ev_ans   = last_ans & ~cfg_wr & ~time_out_i;
  wire        vals_ok  = ~ans_err_ff & byte_ok;
  wire        ev_good  = ev_ans & vals_ok & win2_active_i;
  wire        ev_bad   = ev_ans & ~ev_good;
  wire        seq_end  = ev_cfg | ev_tout | ev_ans;

  assign evt = ev_cfg  ? qa_wd_pkg::EV_CFG  :
               ev_tout ? qa_wd_pkg::EV_TOUT :
               ev_good ? qa_wd_pkg::EV_GOOD :
               ev_bad  ? qa_wd_pkg::EV_BAD  : qa_wd_pkg::EV_NONE;

  // Question chain: a zero state steps as if it held 0001, so it never locks up.
  assign chain_src = (chain_ff == 4'h0) ? 4'h1 : chain_ff;
  assign chain_fb  = (fdbk_ff == qa_wd_pkg::FDBK_X4_X3) ? (chain_src[3] ^ chain_src[2]) :
                     (fdbk_ff == qa_wd_pkg::FDBK_X4_X2) ? (chain_src[3] ^ chain_src[1]) :
                     (fdbk_ff == qa_wd_pkg::FDBK_X3_X2) ? (chain_src[2] ^ chain_src[1]) :
                     (chain_src[3] ^ chain_src[2] ^ chain_src[1]);
  assign nxt_tok_cnt = ev_good ? (tok_cnt_ff + 4'h1) : tok_cnt_ff;
  assign nxt_chain   = (ev_good & (tok_cnt_ff == 4'hF)) ? {chain_src[2:0], chain_fb} :
                       chain_ff;

  // Fail counter saturates at both ends so it can never wrap past the limit.
  assign nxt_fail = (ev_good & (fail_ff != 3'h0)) ? (fail_ff - 3'h1) :
                    ((ev_bad | ev_tout | ev_cfg) & (fail_ff != 3'h7)) ? (fail_ff + 3'h1) :
                    fail_ff;

  // Interrupt set and write-one-to-clear terms.
  wire [3:0] irq_set = {ev_cfg, ev_tout, ev_bad, ev_good};
  wire [3:0] irq_clr = (wr_en & hit_ist) ? dat_i[3:0] : 4'h0;

  // Read data selection; unmapped addresses read as zero.
  wire [31:0] st_word  = {21'h0, fail_ff, 1'b0, cfg_chg_ff, early_ff, tout_ff,
                          seq_error_ff, ans_err_ff, ans_cnt_ff};
  wire [31:0] rd_val   = hit_q    ? {28'h0, question_ff} :
                         hit_fdbk ? {30'h0, fdbk_ff} :
                         hit_win1 ? {24'h0, win1_ff} :
                         hit_win2 ? {24'h0, win2_ff} :
                         hit_st   ? st_word :
                         hit_ist  ? {28'h0, irq_stat_ff} :
                         hit_imsk ? {28'h0, irq_mask_ff} : 32'h0;

  // Bus answer: ack one cycle after the request, dropped in the next cycle.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ack_ff  <= 1'b0;
      rdat_ff <= 32'h0;
    end
    else
    begin
      ack_ff <= req & ~ack_ff;
      if (req & ~ack_ff)
        rdat_ff <= rd_val;
    end
  end

  // Configuration registers written by software.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      fdbk_ff     <= qa_wd_pkg::fdbk_t'(`QA_FDBK_RST);
      win1_ff     <= `QA_WIN_RST;
      win2_ff     <= `QA_WIN_RST;
      irq_mask_ff <= `QA_IRQ_RST;
    end
    else
    begin
      if (wr_en & hit_fdbk)
        fdbk_ff <= qa_wd_pkg::fdbk_t'(dat_i[1:0]);
      if (wr_en & hit_win1)
        win1_ff <= dat_i[7:0];
      if (wr_en & hit_win2)
        win2_ff <= dat_i[7:0];
      if (wr_en & hit_imsk)
        irq_mask_ff <= dat_i[3:0];
    end
  end

  // Question generation and sequence start pulse for the window timer.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      tok_cnt_ff   <= `QA_TOKEN_RST;
      chain_ff     <= `QA_TOKEN_RST;
      question_ff  <= `QA_TOKEN_RST;
      fail_ff      <= `QA_FAIL_RST;
      seq_start_ff <= 1'b0;
    end
    else
    begin
      tok_cnt_ff   <= nxt_tok_cnt;
      chain_ff     <= nxt_chain;
      question_ff  <= nxt_tok_cnt ^ nxt_chain;
      fail_ff      <= nxt_fail;
      seq_start_ff <= seq_end;
    end
  end

  // Answer position and running value check within a sequence.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ans_cnt_ff <= `QA_ANS_CNT_RST;
      ans_err_ff <= 1'b0;
    end
    else if (seq_end)
    begin
      ans_cnt_ff <= `QA_ANS_CNT_RST;
      ans_err_ff <= 1'b0;
    end
    else if (ans_wr)
    begin
      ans_cnt_ff <= ans_cnt_ff - 2'h1;
      ans_err_ff <= ans_err_ff | ~byte_ok;
    end
  end

  // Status flags describe the last sequence that ended.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      {seq_error_ff, tout_ff, early_ff, cfg_chg_ff} <= 4'h0;
    end
    else
    begin
      unique case (evt)
        qa_wd_pkg::EV_GOOD: {seq_error_ff, tout_ff, early_ff, cfg_chg_ff} <= 4'h0;
        qa_wd_pkg::EV_BAD:  {seq_error_ff, tout_ff, early_ff, cfg_chg_ff} <=
                              {1'b1, 1'b0, ~win2_active_i, 1'b0};
        qa_wd_pkg::EV_TOUT: {seq_error_ff, tout_ff, early_ff, cfg_chg_ff} <=
                              {ans_err_ff, 1'b1, 1'b0, 1'b0};
        qa_wd_pkg::EV_CFG:  {seq_error_ff, tout_ff, early_ff, cfg_chg_ff} <= 4'h1;
        qa_wd_pkg::EV_NONE: {seq_error_ff, tout_ff, early_ff, cfg_chg_ff} <=
                              {seq_error_ff, tout_ff, early_ff, cfg_chg_ff};
      endcase
    end
  end

  // Sticky interrupt status; a new event wins over a clear in the same cycle.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      irq_stat_ff <= `QA_IRQ_RST;
    else
      irq_stat_ff <= (irq_stat_ff & ~irq_clr) | irq_set;
  end

  // Outputs, all from flip-flops except the level interrupt.
  assign dat_o           = rdat_ff;
  assign ack_o           = ack_ff;
  assign seq_start_o     = seq_start_ff;
  assign open_window_o   = win1_ff;
  assign closed_window_o = win2_ff;
  assign question_o      = question_ff;
  assign fail_counter_o  = fail_ff;
  assign irq_o           = |(irq_stat_ff & irq_mask_ff);

  // Checks on the sequence evaluation.
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  property p_ref_q0;
    (question_ff == 4'h0) && (ans_cnt_ff == 2'h3) |-> (ref_byte == 8'hFF);
  endproperty
  a_ref_q0: assert property (p_ref_q0)
    else $error("Reference byte for question zero is wrong.");

  property p_ref_flip;
    (ans_cnt_ff == 2'h0) && (question_ff == 4'h1) |-> (ref_byte == 8'h4F);
  endproperty
  a_ref_flip: assert property (p_ref_flip)
    else $error("Last reference byte is not the flipped first byte.");

  property p_good;
    ev_good && (fail_ff != 3'h0) |=>
      (fail_ff == $past(fail_ff) - 3'h1) && !seq_error_ff && !early_ff;
  endproperty
  a_good: assert property (p_good)
    else $error("Good sequence did not lower the fail counter.");

  property p_question_hold;
    !ev_good |=> $stable(question_ff) && $stable(tok_cnt_ff);
  endproperty
  a_question_hold: assert property (p_question_hold)
    else $error("Question changed without a good sequence.");

  property p_bad;
    ev_bad && (fail_ff != 3'h7) |=>
      seq_error_ff && (early_ff == !$past(win2_active_i)) && (fail_ff == $past(fail_ff) + 3'h1);
  endproperty
  a_bad: assert property (p_bad)
    else $error("Bad sequence flags or fail count wrong.");

  property p_tout;
    ev_tout |=> tout_ff && (seq_error_ff == $past(ans_err_ff)) && $stable(question_ff);
  endproperty
  a_tout: assert property (p_tout)
    else $error("Time-out handling wrong.");

  property p_cfg;
    ev_cfg |=> cfg_chg_ff && !seq_error_ff && !tout_ff && !early_ff;
  endproperty
  a_cfg: assert property (p_cfg)
    else $error("Window write did not flag a configuration change.");

  property p_restart;
    seq_end |=> (ans_cnt_ff == 2'h3) && seq_start_o ##1 !seq_start_o [*1];
  endproperty
  a_restart: assert property (p_restart)
    else $error("New sequence did not start within one cycle.");

  property p_step;
    ans_wr && !seq_end |=> (ans_cnt_ff == $past(ans_cnt_ff) - 2'h1);
  endproperty
  a_step: assert property (p_step)
    else $error("Answer counter did not step down.");

  property p_tok_inc;
    ev_good |=> (tok_cnt_ff == $past(tok_cnt_ff) + 4'h1);
  endproperty
  a_tok_inc: assert property (p_tok_inc)
    else $error("Question counter did not advance on a good sequence.");

endmodule : qa_watchdog_answer_check

`default_nettype wire

// >>> design/qa_wd_regs.svh
`ifndef QA_WD_REGS_SVH
`define QA_WD_REGS_SVH

// Byte offsets of the registers on the Wishbone slave.
`define QA_ADR_QUESTION   8'h00
`define QA_ADR_FDBK       8'h04
`define QA_ADR_ANSWER     8'h08
`define QA_ADR_WIN1       8'h0C
`define QA_ADR_WIN2       8'h10
`define QA_ADR_STATE      8'h14
`define QA_ADR_IRQ_STAT   8'h18
`define QA_ADR_IRQ_MASK   8'h1C

// Field positions in the watchdog state register.
`define QA_ST_CNT_LSB     0
`define QA_ST_ANS_ERR     2
`define QA_ST_SEQ_ERROR   3
`define QA_ST_TIME_OUT    4
`define QA_ST_EARLY       5
`define QA_ST_CFG_CHG     6
`define QA_ST_FAIL_LSB    8

// Interrupt status and mask bit positions.
`define QA_IRQ_GOOD       0
`define QA_IRQ_BAD        1
`define QA_IRQ_TOUT       2
`define QA_IRQ_CFG        3

// Reset values.
`define QA_ANS_CNT_RST    2'h3
`define QA_FAIL_RST       3'h0
`define QA_TOKEN_RST      4'h0
`define QA_WIN_RST        8'h00
`define QA_FDBK_RST       2'h0
`define QA_IRQ_RST        4'h0

// Cycles from a sequence end to the new question and sequence start.
`define QA_NEW_SEQ_CYCLES 1

`endif

// >>> design/qa_wd_pkg.sv
`default_nettype none

package qa_wd_pkg;

  // Feedback polynomial of the question chain.
  typedef enum logic [1:0] {
    FDBK_X4_X3 = 2'h0,
    FDBK_X4_X2 = 2'h1,
    FDBK_X3_X2 = 2'h2,
    FDBK_X4_X3_X2 = 2'h3
  } fdbk_t;

  // Kind of event that ends a watchdog sequence, one-hot.
  typedef enum logic [4:0] {
    EV_NONE = 5'h01,
    EV_GOOD = 5'h02,
    EV_BAD  = 5'h04,
    EV_TOUT = 5'h08,
    EV_CFG  = 5'h10
  } event_t;

endpackage : qa_wd_pkg

`default_nettype wire

// >>> design/qa_answer_ref.sv
`default_nettype none

module qa_answer_ref
(
  // Current question and answer position.
  input  wire logic [3:0] question_i,
  input  wire logic [1:0] position_i,
  // Reference answer byte.
  output logic      [7:0] ref_byte_o
);

  logic [7:0] first_byte;
  logic [7:0] flip_mask;

  // Only the first column is stored; the other three are fixed flips of it.
  always_comb
  begin
    unique case (question_i)
      4'h0: first_byte = 8'hFF;
      4'h1: first_byte = 8'hB0;
      4'h2: first_byte = 8'hE9;
      4'h3: first_byte = 8'hA6;
      4'h4: first_byte = 8'h75;
      4'h5: first_byte = 8'h3A;
      4'h6: first_byte = 8'h63;
      4'h7: first_byte = 8'h2C;
      4'h8: first_byte = 8'hD2;
      4'h9: first_byte = 8'h9D;
      4'hA: first_byte = 8'hC4;
      4'hB: first_byte = 8'h8B;
      4'hC: first_byte = 8'h58;
      4'hD: first_byte = 8'h17;
      4'hE: first_byte = 8'h4E;
      4'hF: first_byte = 8'h01;
    endcase
  end

  // The answer position selects the flip mask.
  assign flip_mask  = (position_i == 2'h3) ? 8'h00 :
                      (position_i == 2'h2) ? 8'hF0 :
                      (position_i == 2'h1) ? 8'h0F : 8'hFF;
  assign ref_byte_o = first_byte ^ flip_mask;

endmodule : qa_answer_ref

`default_nettype wire

// >>> test/qa_mcu_model.sv
`default_nettype none

module qa_mcu_model
(
  // System clock.
  input  wire logic clk_i,
  // Window timer lines seen by the block.
  output logic      win2_active_o,
  output logic      time_out_o
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [7:0] first_ans [16];

  // First answer byte per question under the default feedback setting.
  initial
  begin
    first_ans = '{8'hFF, 8'hB0, 8'hE9, 8'hA6, 8'h75, 8'h3A, 8'h63, 8'h2C,
                  8'hD2, 8'h9D, 8'hC4, 8'h8B, 8'h58, 8'h17, 8'h4E, 8'h01};
    win2_active_o = 1'b0;
    time_out_o = 1'b0;
  end

  // The other bytes are the first one flipped, so one column holds the whole table.
  function automatic logic [7:0] answer(input logic [3:0] q, input logic [1:0] pos);
    return first_ans[q] ^ 8'(32'h00F00FFF >> {pos, 3'b000});
  endfunction : answer

  // Opens or closes the window three edges ahead of the edge at which the last answer byte is written.
  task automatic set_window(input logic closed);
    @(posedge clk_i);
    win2_active_o <= closed;
  endtask : set_window

  // A time-out is a single-cycle pulse.
  task automatic pulse_timeout();
    @(posedge clk_i);
    time_out_o <= 1'b1;
    @(posedge clk_i);
    time_out_o <= 1'b0;
  endtask : pulse_timeout
endmodule : qa_mcu_model

`default_nettype wire

// >>> test/tb.sv
`include "qa_wd_regs.svh"
`default_nettype none

module tb;
  timeunit 1ns;
  timeprecision 1ps;

  // Bench-driven bus and clock signals.
  logic        clk_i;
  logic        rst_i;
  logic [7:0]  adr;
  logic [31:0] dat_w;
  logic [3:0]  sel;
  logic        we;
  logic        cyc;
  logic        stb;
  // Block outputs and partner lines.
  logic [31:0] dat_r;
  logic        ack;
  logic        win2;
  logic        tout;
  logic        seq_start;
  logic [7:0]  open_win;
  logic [7:0]  closed_win;
  logic [3:0]  question;
  logic [2:0]  fail_cnt;
  logic        irq;
  // Bookkeeping.
  int          error_cnt = 0;
  int          compares = 0;
  int          cycles = 0;
  int          starts = 0;
  logic [31:0] rd;
  logic [3:0]  q_exp;
  logic [2:0]  f_exp;

  qa_watchdog_answer_check DUT (.clk_i(clk_i), .rst_i(rst_i), .adr_i(adr), .dat_i(dat_w),
    .sel_i(sel), .we_i(we), .cyc_i(cyc), .stb_i(stb), .dat_o(dat_r), .ack_o(ack),
    .win2_active_i(win2), .time_out_i(tout), .seq_start_o(seq_start),
    .open_window_o(open_win), .closed_window_o(closed_win), .question_o(question),
    .fail_counter_o(fail_cnt), .irq_o(irq));

  qa_mcu_model mcu (.clk_i(clk_i), .win2_active_o(win2), .time_out_o(tout));

  // Free-running clock.
  initial
  begin
    clk_i = 1'b0;
    forever #4 clk_i = ~clk_i;
  end

  // Counts sequence starts; a hang ends the run as a failure.
  always @(posedge clk_i)
  begin
    cycles++;
    if (seq_start === 1'b1)
      starts++;
    if (cycles == 20000)
    begin
      error_cnt++;
      wrap_up();
    end
  end

  task automatic wrap_up();
    $display("Comparisons %0d, mismatches %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : wrap_up

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  // One classic cycle; the request stands until ack is sampled high.
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat_w <= d;
    @(posedge clk_i);
    while (ack !== 1'b1)
      @(posedge clk_i);
    rd = dat_r;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask : wb

  // Reads the state word; ANSWER_ERR always reads clear after a sequence end.
  task automatic expect_state(input logic cfg, input logic early, input logic to,
                              input logic seq);
    wb(1'b0, `QA_ADR_STATE, 32'h0);
    check(rd, {21'h0, f_exp, 1'b0, cfg, early, to, seq, 3'b011});
    check({28'h0, question}, {28'h0, q_exp});
    check({29'h0, fail_cnt}, {29'h0, f_exp});
  endtask : expect_state

  // Sends n answer bytes from position 3 down, one of them spoiled if asked.
  task automatic answers(input int n, input int bad_pos, input logic bad, input logic closed);
    for (int p = 3; p > 3 - n; p--)
    begin
      if (p == 0)
        mcu.set_window(closed);
      wb(1'b1, `QA_ADR_ANSWER, {24'h0, mcu.answer(q_exp, 2'(p))
         ^ ((bad && p == bad_pos) ? 8'h5A : 8'h00)});
    end
  endtask : answers

  // Main sequence: bad endings first so that good ones have a count to take down.
  initial
  begin
    rst_i = 1'b1;
    adr = 8'h00;
    dat_w = 32'h0;
    sel = 4'hF;
    we = 1'b0;
    cyc = 1'b0;
    stb = 1'b0;
    q_exp = 4'h0;
    f_exp = 3'h0;
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    expect_state(1'b0, 1'b0, 1'b0, 1'b0);
    wb(1'b1, `QA_ADR_IRQ_MASK, 32'hF);
    answers(4, 0, 1'b0, 1'b0);
    f_exp++;
    expect_state(1'b0, 1'b1, 1'b0, 1'b1);
    check({31'h0, irq}, 32'h1);
    wb(1'b1, `QA_ADR_IRQ_STAT, 32'h2);
    @(posedge clk_i);
    check({31'h0, irq}, 32'h0);
    answers(4, 3, 1'b1, 1'b1);
    f_exp++;
    expect_state(1'b0, 1'b0, 1'b0, 1'b1);
    answers(4, 1, 1'b1, 1'b0);
    f_exp++;
    expect_state(1'b0, 1'b1, 1'b0, 1'b1);
    answers(3, 0, 1'b0, 1'b0);
    mcu.pulse_timeout();
    f_exp++;
    expect_state(1'b0, 1'b0, 1'b1, 1'b0);
    answers(3, 2, 1'b1, 1'b0);
    mcu.pulse_timeout();
    f_exp++;
    expect_state(1'b0, 1'b0, 1'b1, 1'b1);
    wb(1'b0, `QA_ADR_IRQ_STAT, 32'h0);
    check(rd, 32'h6);
    wb(1'b1, `QA_ADR_IRQ_STAT, 32'hF);
    answers(2, 0, 1'b0, 1'b0);
    wb(1'b1, `QA_ADR_WIN1, 32'h5A);
    f_exp++;
    expect_state(1'b1, 1'b0, 1'b0, 1'b0);
    check({24'h0, open_win}, 32'h5A);
    for (int k = 0; k < 2; k++)
    begin
      wb(1'b1, `QA_ADR_WIN2, 32'h33);
      f_exp = 3'h7;
      expect_state(1'b1, 1'b0, 1'b0, 1'b0);
    end
    check({24'h0, closed_win}, 32'h33);
    wb(1'b1, `QA_ADR_IRQ_MASK, 32'h7);
    @(posedge clk_i);
    check({31'h0, irq}, 32'h0);
    wb(1'b1, `QA_ADR_IRQ_MASK, 32'hF);
    @(posedge clk_i);
    check({31'h0, irq}, 32'h1);
    wb(1'b1, `QA_ADR_IRQ_STAT, 32'hF);
    for (int k = 0; k < 15; k++)
    begin
      answers(4, 0, 1'b0, 1'b1);
      q_exp++;
      if (f_exp != 3'h0)
        f_exp--;
      expect_state(1'b0, 1'b0, 1'b0, 1'b0);
    end
    // The sixteenth good sequence wraps the counter and steps the chain from its seed.
    answers(4, 0, 1'b0, 1'b1);
    q_exp = 4'h2;
    expect_state(1'b0, 1'b0, 1'b0, 1'b0);
    wb(1'b1, `QA_ADR_FDBK, 32'h2);
    wb(1'b0, `QA_ADR_FDBK, 32'h0);
    check(rd, 32'h2);
    wb(1'b0, `QA_ADR_IRQ_STAT, 32'h0);
    check(rd, 32'h1);
    wb(1'b0, `QA_ADR_ANSWER, 32'h0);
    check(rd, 32'h0);
    wb(1'b0, 8'h20, 32'h0);
    check(rd, 32'h0);
    check(32'(starts), 32'h18);
    wrap_up();
  end
endmodule : tb

`default_nettype wire
